// ### soc_analog_ch.sv
`timescale 1ns/1ps
`default_nettype none
module soc_analog_ch
  import soc_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_resetn,
  input  wire logic [3:0]        i_source,
  input  wire logic [2:0]        i_span,
  input  wire logic signed [31:0] i_constant_source,
  input  wire logic signed [31:0] i_scale_min,
  input  wire logic signed [31:0] i_scale_max,
  input  wire logic signed [31:0] i_std_min,
  input  wire logic signed [31:0] i_std_max,
  input  wire logic signed [31:0] i_values [9],
  output logic                   o_enable,
  output logic                   o_use_constant_source,
  output logic signed [31:0]     o_sample,
  output logic signed [31:0]     o_lo,
  output logic signed [31:0]     o_hi
);
  logic                next_enable;
  logic                next_use_constant_source;
  logic signed [31:0]  next_sample;
  logic signed [31:0]  next_lo;
  logic signed [31:0]  next_hi;
  logic                two_point;

  always_comb
  begin
    two_point      = !(i_scale_min == 32'sh0 && i_scale_max == 32'sh0);
    next_enable    = (i_span != SPAN_OFF);
    next_use_constant_source = (i_source == 4'h9);
    next_sample    = (i_source <= 4'h8) ? i_values[i_source] : i_constant_source;
    next_lo        = two_point ? i_scale_min : i_std_min;
    next_hi        = two_point ? i_scale_max : i_std_max;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_enable    <= 1'b0;
      o_use_constant_source <= 1'b0;
      o_sample    <= 32'sh0;
      o_lo        <= 32'sh0;
      o_hi        <= 32'sh0;
    end
    else
    begin
      o_enable    <= next_enable;
      o_use_constant_source <= next_use_constant_source;
      o_sample    <= next_sample;
      o_lo        <= next_lo;
      o_hi        <= next_hi;
    end
  end

  a_off_disables: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) i_span == SPAN_OFF |=> !o_enable)
    else $error("span off kept output");
  a_zero_std: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    (i_scale_min == 0 && i_scale_max == 0) |=> o_lo == $past(i_std_min))
    else $error("zero bounds not standard");
endmodule // soc_analog_ch
`default_nettype wire

// ### soc_config.sv
`timescale 1ns/1ps
`default_nettype none
module soc_config
  import soc_pkg::*;
#(
  parameter longint unsigned TUNNEL_WAIT = TUNNEL_WAIT_CYC
)
(
  input  wire logic               i_core_clk,
  input  wire logic               i_resetn,
  // switching outputs
  input  wire logic [3:0]         i_switch_out_a_source,
  input  wire logic [3:0]         i_switch_out_b_source,
  input  wire logic signed [31:0] i_switch_a_lower,
  input  wire logic signed [31:0] i_switch_a_upper,
  input  wire logic signed [31:0] i_switch_b_lower,
  input  wire logic signed [31:0] i_switch_b_upper,
  input  wire logic [3:0]         i_fault_lines,
  input  wire logic signed [31:0] i_values [9],
  output logic                    o_switch_a,
  output logic                    o_switch_b,
  // analog outputs
  input  wire logic [3:0]         i_analog_a_source,
  input  wire logic [3:0]         i_analog_b_source,
  input  wire logic [2:0]         i_analog_a_span,
  input  wire logic [2:0]         i_analog_b_span,
  input  wire logic signed [31:0] i_analog_a_constant_source,
  input  wire logic signed [31:0] i_analog_b_constant_source,
  input  wire logic signed [31:0] i_analog_a_min,
  input  wire logic signed [31:0] i_analog_a_max,
  input  wire logic signed [31:0] i_analog_b_min,
  input  wire logic signed [31:0] i_analog_b_max,
  input  wire logic signed [31:0] i_measuring_span,
  input  wire logic               i_thickness_mode,
  output logic                    o_analog_a_enable,
  output logic                    o_analog_a_constant_source,
  output logic signed [31:0]      o_analog_a_sample,
  output logic signed [31:0]      o_analog_a_lo,
  output logic signed [31:0]      o_analog_a_hi,
  output logic                    o_analog_b_enable,
  output logic                    o_analog_b_constant_source,
  output logic signed [31:0]      o_analog_b_sample,
  output logic signed [31:0]      o_analog_b_lo,
  output logic signed [31:0]      o_analog_b_hi,
  output logic                    o_scale_bad,
  // tunnel: host byte stream in, head byte stream out
  input  wire logic               i_tun_start,
  input  wire logic               i_tun_head,
  input  wire logic [1:0]         i_head_present,
  input  wire logic               i_host_valid,
  input  wire logic [7:0]         i_host_data,
  input  wire logic               i_host_last,
  output logic                    o_head_valid,
  output logic                    o_head_sel,
  output logic [7:0]              o_head_data,
  input  wire logic               i_reply_valid,
  input  wire logic [7:0]         i_reply_data,
  input  wire logic               i_reply_prompt,
  output logic                    o_resp_valid,
  output logic [7:0]              o_resp_data,
  output logic                    o_resp_done,
  output logic                    o_resp_error,
  output logic                    o_tun_busy,
  // lasers
  input  wire logic [1:0]         i_laser_cmd,
  input  wire logic               i_laser_hw_enable,
  output logic [1:0]              o_laser_on,
  // value stream error codes
  input  wire logic signed [31:0] i_stream_value,
  input  wire logic [4:0]         i_stream_err,
  output logic [31:0]             o_usb_value,
  output logic [31:0]             o_eth_value
);
  typedef enum logic [2:0] {
    TS_IDLE = 3'b000, TS_CMD = 3'b001, TS_CR = 3'b011, TS_LF = 3'b010,
    TS_OPEN = 3'b110, TS_REPLY = 3'b111, TS_CLOSE = 3'b101, TS_ERR = 3'b100
  } soc_tun_e;

  // switching outputs
  logic [3:0]         sw_src [2];
  logic signed [31:0] sw_lo [2];
  logic signed [31:0] sw_hi [2];
  logic [1:0]         next_switch;
  logic [1:0]         switch_q;
  assign sw_src[0] = i_switch_out_a_source;
  assign sw_src[1] = i_switch_out_b_source;
  assign sw_lo[0]  = i_switch_a_lower;
  assign sw_hi[0]  = i_switch_a_upper;
  assign sw_lo[1]  = i_switch_b_lower;
  assign sw_hi[1]  = i_switch_b_upper;

  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_sw
      logic signed [31:0] val;
      always_comb
      begin
        val = 32'sh0;
        next_switch[g] = 1'b0;
        unique case (sw_src[g])
          SW_H1_FAULT_A, SW_H1_FAULT_B, SW_H2_FAULT_A, SW_H2_FAULT_B:
            next_switch[g] = i_fault_lines[sw_src[g][1:0]];
          SW_LOW:  next_switch[g] = 1'b0;
          SW_HIGH: next_switch[g] = 1'b1;
          default:
          begin
            val = (sw_src[g] >= 4'h4 && sw_src[g] <= 4'hc) ?
                  i_values[sw_src[g] - 4'h4] : 32'sh0;
            next_switch[g] = (val < sw_lo[g]) || (val > sw_hi[g]);
          end
        endcase
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      switch_q <= 2'h0;
    else
      switch_q <= next_switch;
  end
  assign o_switch_a = switch_q[0];
  assign o_switch_b = switch_q[1];

  // analog outputs; standard bounds
  logic signed [31:0] std_min [2];
  logic signed [31:0] std_max [2];
  logic [3:0]         an_src [2];
  assign an_src[0] = i_analog_a_source;
  assign an_src[1] = i_analog_b_source;
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_std
      always_comb
      begin
        if (an_src[g] == 4'h1 || an_src[g] == 4'h5)
        begin
          std_min[g] = 32'sh0;
          std_max[g] = 32'(VAL_SCALE * 100);
        end
        else if (an_src[g] == 4'h8 && i_thickness_mode)
        begin
          std_min[g] = 32'sh0;
          std_max[g] = i_measuring_span <<< 1;
        end
        else
        begin
          std_min[g] = -(i_measuring_span >>> 1);
          std_max[g] = i_measuring_span >>> 1;
        end
      end
    end
  endgenerate

  soc_analog_ch u_an_a (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_source    (i_analog_a_source),
    .i_span      (i_analog_a_span),
    .i_constant_source     (i_analog_a_constant_source),
    .i_scale_min (i_analog_a_min),
    .i_scale_max (i_analog_a_max),
    .i_std_min   (std_min[0]),
    .i_std_max   (std_max[0]),
    .i_values    (i_values),
    .o_enable    (o_analog_a_enable),
    .o_use_constant_source (o_analog_a_constant_source),
    .o_sample    (o_analog_a_sample),
    .o_lo        (o_analog_a_lo),
    .o_hi        (o_analog_a_hi)
  );
  soc_analog_ch u_an_b (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_source    (i_analog_b_source),
    .i_span      (i_analog_b_span),
    .i_constant_source     (i_analog_b_constant_source),
    .i_scale_min (i_analog_b_min),
    .i_scale_max (i_analog_b_max),
    .i_std_min   (std_min[1]),
    .i_std_max   (std_max[1]),
    .i_values    (i_values),
    .o_enable    (o_analog_b_enable),
    .o_use_constant_source (o_analog_b_constant_source),
    .o_sample    (o_analog_b_sample),
    .o_lo        (o_analog_b_lo),
    .o_hi        (o_analog_b_hi)
  );

  // bounds out of range flag
  logic next_scale_bad;
  logic scale_bad;
  always_comb
  begin
    next_scale_bad = (i_analog_a_min < -SCALE_BOUND) ||
                     (i_analog_a_max > SCALE_BOUND) ||
                     (i_analog_b_min < -SCALE_BOUND) ||
                     (i_analog_b_max > SCALE_BOUND);
  end
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      scale_bad <= 1'b0;
    else
      scale_bad <= next_scale_bad;
  end
  assign o_scale_bad = scale_bad;

  // tunnel
  soc_tun_e        st;
  soc_tun_e        next_st;
  logic            head;
  logic            next_head;
  logic [31:0]     wait_cnt;
  logic [31:0]     next_wait_cnt;
  logic            next_head_valid;
  logic [7:0]      next_head_data;
  logic            next_resp_valid;
  logic [7:0]      next_resp_data;
  logic            next_resp_done;
  logic            next_resp_error;

  always_comb
  begin
    next_st         = st;
    next_head       = head;
    next_wait_cnt   = wait_cnt;
    next_head_valid = 1'b0;
    next_head_data  = o_head_data;
    next_resp_valid = 1'b0;
    next_resp_data  = o_resp_data;
    next_resp_done  = 1'b0;
    next_resp_error = 1'b0;
    unique case (st)
      TS_IDLE:
        if (i_tun_start)
        begin
          next_head = i_tun_head;
          if (!i_head_present[i_tun_head])
            next_st = TS_ERR;
          else
            next_st = TS_CMD;
        end
      TS_CMD:
        if (i_host_valid)
        begin
          if (i_host_data != CH_QUOTE)
          begin
            next_head_valid = 1'b1;
            next_head_data  = i_host_data;
          end
          if (i_host_last)
            next_st = TS_CR;
        end
      TS_CR:
      begin
        next_head_valid = 1'b1;
        next_head_data  = CH_CR;
        next_st         = TS_LF;
      end
      TS_LF:
      begin
        next_head_valid = 1'b1;
        next_head_data  = CH_LF;
        next_st         = TS_OPEN;
      end
      TS_OPEN:
      begin
        next_resp_valid = 1'b1;
        next_resp_data  = CH_QUOTE;
        next_wait_cnt   = 32'h0;
        next_st         = TS_REPLY;
      end
      TS_REPLY:
        if (i_reply_prompt)
          next_st = TS_CLOSE;
        else if (i_reply_valid)
        begin
          next_resp_valid = 1'b1;
          next_resp_data  = i_reply_data;
        end
        else if (64'(wait_cnt) >= TUNNEL_WAIT - 64'h1)
          next_st = TS_ERR;
        else
          next_wait_cnt = wait_cnt + 32'h1;
      TS_CLOSE:
      begin
        next_resp_valid = 1'b1;
        next_resp_data  = CH_QUOTE;
        next_resp_done  = 1'b1;
        next_st         = TS_IDLE;
      end
      TS_ERR:
      begin
        next_resp_error = 1'b1;
        next_resp_done  = 1'b1;
        next_st         = TS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st           <= TS_IDLE;
      head         <= 1'b0;
      wait_cnt     <= 32'h0;
      o_head_valid <= 1'b0;
      o_head_data  <= 8'h0;
      o_resp_valid <= 1'b0;
      o_resp_data  <= 8'h0;
      o_resp_done  <= 1'b0;
      o_resp_error <= 1'b0;
    end
    else
    begin
      st           <= next_st;
      head         <= next_head;
      wait_cnt     <= next_wait_cnt;
      o_head_valid <= next_head_valid;
      o_head_data  <= next_head_data;
      o_resp_valid <= next_resp_valid;
      o_resp_data  <= next_resp_data;
      o_resp_done  <= next_resp_done;
      o_resp_error <= next_resp_error;
    end
  end
  assign o_head_sel = head;
  assign o_tun_busy = (st != TS_IDLE);

  // lasers and stream codes
  logic [1:0]  next_laser;
  logic [1:0]  laser_q;
  logic [31:0] next_usb;
  logic [31:0] next_eth;
  always_comb
  begin
    next_laser = i_laser_cmd & {2{i_laser_hw_enable}};
    next_usb = 32'(i_stream_value);
    if (i_stream_err[4])      next_usb = USB_ERR_GLOBAL;
    else if (i_stream_err[3]) next_usb = USB_ERR_NOCALC;
    else if (i_stream_err[2]) next_usb = USB_ERR_RATE;
    else if (i_stream_err[1]) next_usb = USB_ERR_OVER;
    else if (i_stream_err[0]) next_usb = USB_ERR_UNDER;
    next_eth = 32'(i_stream_value);
    if (i_stream_err[4])      next_eth = ETH_ERR_GLOBAL;
    else if (i_stream_err[3]) next_eth = ETH_ERR_NOCALC;
  end
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      laser_q     <= 2'h0;
      o_usb_value <= 32'h0;
      o_eth_value <= 32'h0;
    end
    else
    begin
      laser_q     <= next_laser;
      o_usb_value <= next_usb;
      o_eth_value <= next_eth;
    end
  end
  assign o_laser_on = laser_q;

  a_switch_high: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) i_switch_out_b_source == SW_HIGH |=> o_switch_b)
    else $error("high lost");
  a_switch_range: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) i_switch_out_a_source == SW_H1_DIST &&
    (i_values[0] < i_switch_a_lower || i_values[0] > i_switch_a_upper)
    |=> o_switch_a) else $error("out of limits not flagged");
  a_laser_gate: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) !i_laser_hw_enable |=> o_laser_on == 2'h0)
    else $error("laser without enable");
  a_no_head_err: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    (st == TS_IDLE && i_tun_start && !i_head_present[i_tun_head])
    |=> ##1 o_resp_error) else $error("missing head not refused");
  a_crlf_order: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    st == TS_CR |=> o_head_data == CH_CR ##1 o_head_data == CH_LF)
    else $error("crlf missing");
  a_usb_global: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) i_stream_err[4] |=> o_usb_value == USB_ERR_GLOBAL)
    else $error("usb code");
  a_eth_nocalc: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    i_stream_err[4:3] == 2'b01 |=> o_eth_value == ETH_ERR_NOCALC)
    else $error("eth code");
  a_reply_wrap: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    st == TS_CLOSE |=> o_resp_valid && o_resp_data == CH_QUOTE && o_resp_done)
    else $error("closing quote missing");
  a_wait_bound: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) st == TS_REPLY |-> 64'(wait_cnt) < TUNNEL_WAIT)
    else $error("timeout late");
endmodule // soc_config
`default_nettype wire

// ### soc_head_model.sv
`timescale 1ns/1ps
`default_nettype none
module soc_head_model
  import soc_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_head_valid,
  input  wire logic [7:0] i_head_data,
  input  wire logic       i_silent,
  input  wire logic       i_slow,
  output logic            o_reply_valid,
  output logic [7:0]      o_reply_data,
  output logic            o_reply_prompt
);
  logic [7:0] msg [2] = '{8'h4f, 8'h4b};
  initial
  begin
    o_reply_valid = 1'b0;
    o_reply_data = 8'h00;
    o_reply_prompt = 1'b0;
    forever
    begin
      @(posedge i_core_clk);
      // a command ends at the line feed
      if (i_head_valid && i_head_data == CH_LF)
      begin
        repeat (i_slow ? 20 : 2) @(posedge i_core_clk);
        for (int k = 0; k < 2; k++)
        begin
          o_reply_valid <= 1'b1;
          o_reply_data <= msg[k];
          @(posedge i_core_clk);
          o_reply_valid <= 1'b0;
          o_reply_data <= ~msg[k];
          repeat (3) @(posedge i_core_clk);
        end
        // silent head never prompts
        if (!i_silent)
          o_reply_prompt <= 1'b1;
        @(posedge i_core_clk);
        o_reply_prompt <= 1'b0;
      end
    end
  end
endmodule // soc_head_model
`default_nettype wire

// ### soc_pkg.sv
package soc_pkg;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned TUNNEL_WAIT_MS = 15000;
  localparam longint unsigned TUNNEL_WAIT_CYC =
    longint'(TUNNEL_WAIT_MS) * longint'(CLK_HZ) / 1000;
  localparam int unsigned VAL_W   = 32;
  localparam int unsigned VAL_SCALE = 10000;
  localparam logic signed [31:0] SCALE_BOUND = 32'sd10240000;
  localparam logic [31:0] USB_ERR_UNDER  = 32'd262073;
  localparam logic [31:0] USB_ERR_OVER   = 32'd262074;
  localparam logic [31:0] USB_ERR_RATE   = 32'd262075;
  localparam logic [31:0] USB_ERR_NOCALC = 32'd262079;
  localparam logic [31:0] USB_ERR_GLOBAL = 32'd262080;
  localparam logic [31:0] ETH_ERR_NOCALC = 32'h07fffff8;
  localparam logic [31:0] ETH_ERR_GLOBAL = 32'h07fffff7;
  localparam logic [7:0] CH_QUOTE = 8'h22;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [3:0] SW_SRC_RESET = 4'h0;
  localparam logic [2:0] SPAN_RESET   = 3'h0;
  typedef enum logic [3:0] {
    SW_H1_FAULT_A = 4'h0, SW_H1_FAULT_B = 4'h1,
    SW_H2_FAULT_A = 4'h2, SW_H2_FAULT_B = 4'h3,
    SW_H1_DIST = 4'h4, SW_H1_LEVEL = 4'h5, SW_H1_EXPO = 4'h6,
    SW_H1_REFL = 4'h7, SW_H2_DIST = 4'h8, SW_H2_LEVEL = 4'h9,
    SW_H2_EXPO = 4'ha, SW_H2_REFL = 4'hb, SW_COMBINED = 4'hc,
    SW_LOW = 4'hd, SW_HIGH = 4'he
  } soc_sw_src_e;
  typedef enum logic [2:0] {
    SPAN_OFF = 3'h0, SPAN_0_5V = 3'h1, SPAN_0_10V = 3'h2,
    SPAN_PM5V = 3'h3, SPAN_PM10V = 3'h4, SPAN_4_20MA = 3'h5
  } soc_span_e;
endpackage

// ### tb_sensor_output_config_interp.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_output_config_interp;
  import soc_pkg::*;
  logic i_core_clk = 1'b0, i_resetn = 1'b0, i_thickness_mode = 1'b1;
  logic i_tun_start = 1'b0, i_tun_head = 1'b0, i_host_valid = 1'b0;
  logic i_host_last = 1'b0, i_laser_hw_enable = 1'b0;
  logic silent = 1'b0, slow = 1'b0, sel_seen = 1'b0, got_done, got_err;
  logic i_reply_valid, i_reply_prompt;
  logic [3:0] i_switch_out_a_source = 4'h0, i_switch_out_b_source = 4'h0;
  logic [3:0] i_fault_lines = 4'h0, i_analog_a_source = 4'h0;
  logic [3:0] i_analog_b_source = 4'h0;
  logic [2:0] i_analog_a_span = 3'h0, i_analog_b_span = 3'h2;
  logic signed [31:0] i_switch_a_lower = -32'sd5000;
  logic signed [31:0] i_switch_a_upper = 32'sd20000;
  logic signed [31:0] i_switch_b_lower = -32'sd20000;
  logic signed [31:0] i_switch_b_upper = 32'sd5000;
  logic signed [31:0] i_analog_a_constant_source = 32'sd12345;
  logic signed [31:0] i_analog_b_constant_source = 32'sd7777, i_analog_a_min = 32'sd0;
  logic signed [31:0] i_analog_a_max = 32'sd0, i_measuring_span = 32'sd20000;
  logic signed [31:0] i_analog_b_min = -32'sd10240000;
  logic signed [31:0] i_analog_b_max = 32'sd10240000;
  logic signed [31:0] i_stream_value = 32'sh1234, i_values [9];
  logic [1:0] i_head_present = 2'h0, i_laser_cmd = 2'h0, o_laser_on;
  logic [7:0] i_host_data = 8'h00, i_reply_data, o_head_data, o_resp_data;
  logic [4:0] i_stream_err = 5'h0;
  logic o_switch_a, o_switch_b, o_analog_a_enable, o_analog_a_constant_source;
  logic o_analog_b_enable, o_analog_b_constant_source, o_scale_bad, o_head_valid;
  logic o_head_sel, o_resp_valid, o_resp_done, o_resp_error, o_tun_busy;
  logic signed [31:0] o_analog_a_sample, o_analog_a_lo, o_analog_a_hi;
  logic signed [31:0] o_analog_b_sample, o_analog_b_lo, o_analog_b_hi;
  logic [31:0] o_usb_value, o_eth_value;
  logic [7:0] head_q [$], resp_q [$];
  int miscompares = 0, tests_run = 0, cycles = 0;

  soc_config #(.TUNNEL_WAIT(50)) u_dut (.*);
  soc_head_model u_head (
    .i_core_clk     (i_core_clk),
    .i_head_valid   (o_head_valid),
    .i_head_data    (o_head_data),
    .i_silent       (silent),
    .i_slow         (slow),
    .o_reply_valid  (i_reply_valid),
    .o_reply_data   (i_reply_data),
    .o_reply_prompt (i_reply_prompt)
  );

  initial
  begin
    forever #25 i_core_clk = ~i_core_clk;
  end

  // watchdog and capture of the byte streams
  always @(posedge i_core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      stop_test();
    end
    if (o_head_valid)
    begin
      head_q.push_back(o_head_data);
      sel_seen = o_head_sel;
    end
    if (o_resp_valid)
      resp_q.push_back(o_resp_data);
    if (o_resp_done)
    begin
      got_done = 1'b1;
      got_err = o_resp_error;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle;
    repeat (2) @(posedge i_core_clk);
    #1;
  endtask

  task automatic stop_test;
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic sw_exp(int s, logic b);
    logic signed [31:0] lo, hi;
    lo = b ? i_switch_b_lower : i_switch_a_lower;
    hi = b ? i_switch_b_upper : i_switch_a_upper;
    if (s < 4)
      return i_fault_lines[s];
    if (s < 13)
      return i_values[s-4] < lo || i_values[s-4] > hi;
    return s == 14;
  endfunction

  function automatic logic signed [31:0] std_b(int s, logic hi);
    if (s == 1 || s == 5)
      return hi ? 32'sd1000000 : 32'sd0;
    if (s == 8)
      return hi ? 2 * i_measuring_span : 32'sd0;
    return hi ? i_measuring_span / 2 : -(i_measuring_span / 2);
  endfunction

  function automatic logic [31:0] err_exp(int k, logic eth);
    if (k[4])
      return eth ? ETH_ERR_GLOBAL : USB_ERR_GLOBAL;
    if (k[3])
      return eth ? ETH_ERR_NOCALC : USB_ERR_NOCALC;
    if (eth || k[2:0] == 0)
      return i_stream_value;
    return k[2] ? USB_ERR_RATE : k[1] ? USB_ERR_OVER : USB_ERR_UNDER;
  endfunction

  task automatic tunnel(input logic h, input logic [1:0] pres,
                        input logic sil, input logic sl);
    logic [7:0] cmd [4];
    logic [7:0] hx [4];
    logic [7:0] rx [4];
    logic err;
    int n;
    cmd = '{CH_QUOTE, 8'h41, 8'h42, CH_QUOTE};
    hx = '{8'h41, 8'h42, CH_CR, CH_LF};
    rx = '{CH_QUOTE, 8'h4f, 8'h4b, CH_QUOTE};
    err = !pres[h] || sil;
    n = 0;
    head_q.delete();
    resp_q.delete();
    got_done = 1'b0;
    @(posedge i_core_clk);
    i_tun_head <= h;
    i_head_present <= pres;
    silent <= sil;
    slow <= sl;
    i_tun_start <= 1'b1;
    @(posedge i_core_clk);
    i_tun_start <= 1'b0;
    @(posedge i_core_clk);
    if (pres[h])
      for (int k = 0; k < 4; k++)
      begin
        i_host_valid <= 1'b1;
        i_host_data <= cmd[k];
        i_host_last <= k == 3;
        @(posedge i_core_clk);
      end
    i_host_valid <= 1'b0;
    i_host_last <= 1'b0;
    while (got_done !== 1'b1 && n < 200)
    begin
      @(posedge i_core_clk);
      n++;
    end
    chk(got_done, 1'b1);
    chk(got_err, err);
    if (sil)
      chk(n > 40, 1'b1);
    if (!pres[h])
      chk(n < 6, 1'b1);
    if (pres[h])
    begin
      chk(head_q.size(), 4);
      foreach (hx[k]) chk(head_q[k], hx[k]);
      chk(sel_seen, h);
    end
    else
      chk(head_q.size(), 0);
    if (!err)
    begin
      chk(resp_q.size(), 4);
      foreach (rx[k]) chk(resp_q[k], rx[k]);
    end
    settle();
    chk(o_tun_busy, 1'b0);
  endtask

  initial
  begin
    foreach (i_values[i]) i_values[i] = 32'sd10000 * i - 32'sd30000;
    repeat (10) @(posedge i_core_clk);
    chk(o_usb_value, 32'h0);
    i_resetn <= 1'b1;
    for (int f = 5; f < 11; f += 5)
      for (int s = 0; s < 15; s++)
      begin
        @(posedge i_core_clk);
        i_fault_lines <= 4'(f);
        i_switch_out_a_source <= 4'(s);
        i_switch_out_b_source <= 4'(s);
        settle();
        chk(o_switch_a, sw_exp(s, 1'b0));
        chk(o_switch_b, sw_exp(s, 1'b1));
      end
    for (int s = 0; s < 10; s++)
    begin
      @(posedge i_core_clk);
      i_analog_a_source <= 4'(s);
      i_analog_b_source <= 4'(s);
      i_analog_a_span <= 3'(s % 6);
      settle();
      chk(o_analog_a_enable, s % 6 != 0);
      chk(o_analog_a_constant_source, s == 9);
      chk(o_analog_a_sample, s < 9 ? i_values[s] : i_analog_a_constant_source);
      chk(o_analog_b_enable, 1'b1);
      chk(o_analog_b_constant_source, s == 9);
      chk(o_analog_b_sample, s < 9 ? i_values[s] : i_analog_b_constant_source);
      if (s < 9)
      begin
        chk(o_analog_a_lo, std_b(s, 1'b0));
        chk(o_analog_a_hi, std_b(s, 1'b1));
      end
      chk(o_analog_b_lo, i_analog_b_min);
      chk(o_analog_b_hi, i_analog_b_max);
      chk(o_scale_bad, 1'b0);
    end
    @(posedge i_core_clk);
    i_analog_a_max <= 32'sd5;
    i_analog_b_max <= SCALE_BOUND + 1;
    settle();
    chk(o_analog_a_lo, 32'sd0);
    chk(o_analog_a_hi, 32'sd5);
    chk(o_scale_bad, 1'b1);
    for (int k = 0; k < 8; k++)
    begin
      @(posedge i_core_clk);
      i_laser_cmd <= 2'(k);
      i_laser_hw_enable <= k[2];
      settle();
      chk(o_laser_on, 2'(k) & {2{k[2]}});
    end
    for (int k = 0; k < 32; k++)
    begin
      @(posedge i_core_clk);
      i_stream_err <= 5'(k);
      settle();
      chk(o_usb_value, err_exp(k, 1'b0));
      chk(o_eth_value, err_exp(k, 1'b1));
    end
    tunnel(1'b0, 2'b11, 1'b0, 1'b0);
    tunnel(1'b1, 2'b11, 1'b0, 1'b1);
    tunnel(1'b0, 2'b10, 1'b0, 1'b0);
    tunnel(1'b1, 2'b01, 1'b0, 1'b0);
    tunnel(1'b0, 2'b11, 1'b1, 1'b0);
    stop_test();
  end
endmodule // tb_sensor_output_config_interp
`default_nettype wire
